// ===== src/sfc_top.sv
// Stand-alone frame clock, tone and message slot source
`timescale 1ns/1ps
`include "sfc_cfg.svh"
module sfc_top #(
    parameter int RAM_AW = 5
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        OSC_CLK_IN,
    input  wire logic [4:0]  PROC_ADDR_IN,
    input  wire logic [7:0]  PROC_DATA_IN,
    input  wire logic        PROC_STROBE_N_IN,
    input  wire logic        PROC_WRITE_N_IN,
    output logic      [7:0]  PROC_DATA_OUT,
    output logic             PROC_DATA_OE_OUT,
    output logic             PROC_DATA_ACKNOWLEDGE_N_OUT,
    input  wire logic [1:0]  LINK_BIT_CLOCK_IN,
    input  wire logic [1:0]  MULTIFRAME_PULSE_IN,
    input  wire logic        MSG_RX_IN,
    output logic             MSG_TX_OUT,
    output logic             LINK_BIT_CLOCK_OUT,
    output logic             MULTIFRAME_PULSE_OUT,
    output logic             STANDALONE_MODE_OUT,
    output logic             HOST_SLOT_TO_DEVICE_OUT,
    output logic             MAINT_SLOT_TO_CARD_OUT,
    output logic             TRUNK_MSG_SLOT_OUT,
    input  wire logic [7:0]  TONE_ROM_DATA_IN,
    output logic      [12:0] TONE_ROM_ADDR_OUT,
    output logic      [7:0]  TONE_PORT_OUT,
    output logic             LOCAL_FRAME_PULSE_OUT,
    output logic             WIDTH_PULSE_OUT
);
    localparam int RAM_DEPTH = 1 << RAM_AW;

    // Synchronised pins
    logic [14:0] bus_sync;
    logic [4:0]  link_sync;
    logic [7:0]  rom_sync;
    logic        strobe;
    logic        write_en;
    logic [4:0]  addr;
    logic [7:0]  wdata;

    // Oscillator domain
    logic        osc_rst;
    logic        osc_req;
    logic        frame_toggle;
    logic        frame_toggle_sys;
    logic        frame_toggle_seen;
    logic        frame_event;

    // Registers
    logic [7:0]  ctrl;
    logic [10:0] width_shadow;
    logic [2:0]  width_hi_hold;
    logic        width_req;
    logic [15:0] phase_count;
    logic [15:0] phase_cap;
    logic [RAM_AW-1:0] ram_ptr;
    logic        standalone;
    logic        link_sel;

    // Message engine
    logic        bclk_sel;
    logic        bclk_prev;
    logic        mf_sel;
    logic        mf_prev;
    logic        bit_tick;
    logic        mf_rise;
    logic [2:0]  bit_cnt;
    logic [4:0]  slot_cnt;
    logic        in_msg_slot;
    logic        hw_busy;
    logic        byte_done;
    logic [7:0]  rx_shift;
    logic [7:0]  tx_shift;
    logic [3:0]  msg_ptr;
    logic [7:0]  msg_ram [RAM_DEPTH];

    // Bus
    sfc_pkg::sfc_bus_state_t bus_state;
    sfc_pkg::sfc_bus_state_t next_bus_state;
    logic        do_access;
    logic        ram_access;
    logic [7:0]  next_rdata;

    sfc_sync #(.WIDTH(15)) u_bus_sync (
        .clk_in (SYS_CLK_IN),
        .rst_in (RST_IN),
        .d_in   ({~PROC_STROBE_N_IN, ~PROC_WRITE_N_IN, PROC_ADDR_IN, PROC_DATA_IN}),
        .q_out  (bus_sync)
    );

    sfc_sync #(.WIDTH(5)) u_link_sync (
        .clk_in (SYS_CLK_IN),
        .rst_in (RST_IN),
        .d_in   ({MSG_RX_IN, MULTIFRAME_PULSE_IN, LINK_BIT_CLOCK_IN}),
        .q_out  (link_sync)
    );

    sfc_sync #(.WIDTH(8)) u_rom_sync (
        .clk_in (SYS_CLK_IN),
        .rst_in (RST_IN),
        .d_in   (TONE_ROM_DATA_IN),
        .q_out  (rom_sync)
    );

    sfc_sync #(.WIDTH(1)) u_frame_sync (
        .clk_in (SYS_CLK_IN),
        .rst_in (RST_IN),
        .d_in   (frame_toggle),
        .q_out  (frame_toggle_sys)
    );

    // Reset is carried into the oscillator domain; it lasts while RST_IN does
    sfc_sync #(.WIDTH(1)) u_osc_rst_sync (
        .clk_in (OSC_CLK_IN),
        .rst_in (1'b0),
        .d_in   (RST_IN),
        .q_out  (osc_rst)
    );

    sfc_sync #(.WIDTH(1)) u_req_sync (
        .clk_in (OSC_CLK_IN),
        .rst_in (osc_rst),
        .d_in   (width_req),
        .q_out  (osc_req)
    );

    sfc_frame_gen #(.CW(11)) u_frame_gen (
        .clk_in                (OSC_CLK_IN),
        .rst_in                (osc_rst),
        .width_req_in          (osc_req),
        .width_in              (width_shadow),
        .local_frame_pulse_out (LOCAL_FRAME_PULSE_OUT),
        .width_pulse_out       (WIDTH_PULSE_OUT),
        .frame_toggle_out      (frame_toggle)
    );

    assign strobe      = bus_sync[14];
    assign write_en    = bus_sync[13];
    assign addr        = bus_sync[12:8];
    assign wdata       = bus_sync[7:0];
    assign standalone  = ctrl[`SFC_CTRL_MODE_BIT];
    assign link_sel    = ctrl[`SFC_CTRL_SEL_BIT];
    assign frame_event = (frame_toggle_sys != frame_toggle_seen);

    // Source card selection
    assign bclk_sel = link_sel ? link_sync[1] : link_sync[0];
    assign mf_sel   = link_sel ? link_sync[3] : link_sync[2];
    assign bit_tick = bclk_sel & ~bclk_prev;
    assign mf_rise  = mf_sel & ~mf_prev;

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            bclk_prev            <= 1'b0;
            mf_prev              <= 1'b0;
            frame_toggle_seen    <= 1'b0;
            LINK_BIT_CLOCK_OUT   <= 1'b0;
            MULTIFRAME_PULSE_OUT <= 1'b0;
        end else begin
            bclk_prev            <= bclk_sel;
            mf_prev              <= mf_sel;
            frame_toggle_seen    <= frame_toggle_sys;
            LINK_BIT_CLOCK_OUT   <= bclk_sel;
            MULTIFRAME_PULSE_OUT <= mf_sel;
        end
    end

    // Bit and slot position, realigned at each multiframe pulse
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || mf_rise) begin
            bit_cnt  <= '0;
            slot_cnt <= '0;
        end else if (bit_tick) begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == `SFC_BIT_LAST) begin
                slot_cnt <= slot_cnt + 1'b1;
            end
        end
    end

    assign in_msg_slot = standalone ? (slot_cnt == `SFC_SLOT_HOST)
                                    : (slot_cnt == `SFC_SLOT_TRUNK);
    // The whole message slot is held against the processor, not just the write cycle
    assign hw_busy     = in_msg_slot;
    assign byte_done   = in_msg_slot && bit_tick && (bit_cnt == `SFC_BIT_LAST);

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            HOST_SLOT_TO_DEVICE_OUT <= 1'b0;
            MAINT_SLOT_TO_CARD_OUT  <= 1'b0;
            TRUNK_MSG_SLOT_OUT      <= 1'b0;
            STANDALONE_MODE_OUT     <= 1'b0;
        end else begin
            HOST_SLOT_TO_DEVICE_OUT <= standalone && (slot_cnt == `SFC_SLOT_HOST);
            MAINT_SLOT_TO_CARD_OUT  <= standalone && (slot_cnt == `SFC_SLOT_MAINT);
            TRUNK_MSG_SLOT_OUT      <= !standalone && (slot_cnt == `SFC_SLOT_TRUNK);
            STANDALONE_MODE_OUT     <= standalone;
        end
    end

    // Serial message bytes; low half of RAM receives, high half transmits
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            rx_shift   <= '0;
            tx_shift   <= '0;
            msg_ptr    <= '0;
            MSG_TX_OUT <= 1'b0;
        end else if (in_msg_slot && bit_tick) begin
            rx_shift   <= {rx_shift[6:0], link_sync[4]};
            MSG_TX_OUT <= tx_shift[7];
            if (bit_cnt == `SFC_BIT_LAST) begin
                tx_shift <= msg_ram[`SFC_RAM_TX_BASE | {1'b0, msg_ptr + 1'b1}];
                msg_ptr  <= msg_ptr + 1'b1;
            end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    // Message RAM: hardware write at slot end, processor write only outside the slot
    always_ff @(posedge SYS_CLK_IN) begin
        if (byte_done) begin
            msg_ram[{1'b0, msg_ptr}] <= {rx_shift[6:0], link_sync[4]};
        end else if (do_access && ram_access && write_en) begin
            msg_ram[ram_ptr] <= wdata;
        end
    end

    // Processor bus handshake
    assign ram_access = (addr == `SFC_REG_RAM_DATA);

    always_comb begin
        next_bus_state = bus_state;
        do_access      = 1'b0;
        case (bus_state)
            sfc_pkg::SFC_BUS_IDLE: begin
                if (strobe) begin
                    if (ram_access && hw_busy) begin
                        next_bus_state = sfc_pkg::SFC_BUS_WAIT;
                    end else begin
                        do_access      = 1'b1;
                        next_bus_state = sfc_pkg::SFC_BUS_ACK;
                    end
                end
            end
            sfc_pkg::SFC_BUS_WAIT: begin
                if (!strobe) begin
                    next_bus_state = sfc_pkg::SFC_BUS_IDLE;
                end else if (!hw_busy) begin
                    do_access      = 1'b1;
                    next_bus_state = sfc_pkg::SFC_BUS_ACK;
                end
            end
            sfc_pkg::SFC_BUS_ACK: begin
                if (!strobe) begin
                    next_bus_state = sfc_pkg::SFC_BUS_IDLE;
                end
            end
            default: begin
                next_bus_state = sfc_pkg::SFC_BUS_IDLE;
            end
        endcase
    end

    always_comb begin
        case (addr)
            `SFC_REG_CTRL:     next_rdata = ctrl;
            `SFC_REG_WIDTH_LO: next_rdata = width_shadow[7:0];
            `SFC_REG_WIDTH_HI: next_rdata = {5'h00, width_shadow[10:8]};
            `SFC_REG_PHASE_LO: next_rdata = phase_cap[7:0];
            `SFC_REG_PHASE_HI: next_rdata = phase_cap[15:8];
            `SFC_REG_RAM_PTR:  next_rdata = {{(8 - RAM_AW){1'b0}}, ram_ptr};
            `SFC_REG_RAM_DATA: next_rdata = msg_ram[ram_ptr];
            `SFC_REG_STATUS:   next_rdata = {7'h00, hw_busy};
            default:           next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            bus_state                   <= sfc_pkg::SFC_BUS_IDLE;
            PROC_DATA_ACKNOWLEDGE_N_OUT <= 1'b1;
            PROC_DATA_OE_OUT            <= 1'b0;
            PROC_DATA_OUT               <= 8'h00;
        end else begin
            bus_state <= next_bus_state;
            if (do_access) begin
                PROC_DATA_ACKNOWLEDGE_N_OUT <= 1'b0;
                PROC_DATA_OE_OUT            <= !write_en;
                PROC_DATA_OUT               <= write_en ? 8'h00 : next_rdata;
            end else if (!strobe) begin
                PROC_DATA_ACKNOWLEDGE_N_OUT <= 1'b1;
                PROC_DATA_OE_OUT            <= 1'b0;
            end
        end
    end

    // Writable registers
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            ctrl          <= `SFC_CTRL_RST;
            width_shadow  <= `SFC_WIDTH_RST;
            width_hi_hold <= '0;
            width_req     <= 1'b0;
            ram_ptr       <= '0;
        end else if (do_access && write_en) begin
            case (addr)
                `SFC_REG_CTRL:     ctrl <= wdata;
                `SFC_REG_WIDTH_HI: width_hi_hold <= wdata[2:0];
                `SFC_REG_WIDTH_LO: begin
                    // Low byte commits the pair; out-of-range widths are clamped
                    if ({width_hi_hold, wdata} > `SFC_WIDTH_MAX) begin
                        width_shadow <= `SFC_WIDTH_MAX;
                    end else if ({width_hi_hold, wdata} < `SFC_WIDTH_MIN) begin
                        width_shadow <= `SFC_WIDTH_MIN;
                    end else begin
                        width_shadow <= {width_hi_hold, wdata};
                    end
                    width_req <= ~width_req;
                end
                `SFC_REG_RAM_PTR:  ram_ptr <= wdata[RAM_AW-1:0];
                default: begin
                end
            endcase
        end
    end

    // Phase of the received multiframe pulse against the local frame, for software logging
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            phase_count <= '0;
            phase_cap   <= '0;
        end else begin
            if (frame_event) begin
                phase_count <= '0;
            end else if (phase_count != 16'hffff) begin
                phase_count <= phase_count + 1'b1;
            end
            if (mf_rise) begin
                phase_cap <= phase_count;
            end
        end
    end

    // Tone ROM stepped once per local frame; data lines 0 to 4 each carry one tone, lines 5 to 7 are unused
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || !standalone) begin
            TONE_ROM_ADDR_OUT <= '0;
            TONE_PORT_OUT     <= 8'h00;
        end else begin
            if (frame_event) begin
                TONE_ROM_ADDR_OUT <= (TONE_ROM_ADDR_OUT == `SFC_ROM_LAST) ? 13'h0000
                                                                          : TONE_ROM_ADDR_OUT + 1'b1;
            end
            TONE_PORT_OUT                     <= 8'h00;
            TONE_PORT_OUT[`SFC_PORT_DIAL]     <= rom_sync[`SFC_TONE_DIAL];
            TONE_PORT_OUT[`SFC_PORT_BUSY]     <= rom_sync[`SFC_TONE_BUSY];
            TONE_PORT_OUT[`SFC_PORT_RINGBACK] <= rom_sync[`SFC_TONE_RINGBACK];
            TONE_PORT_OUT[`SFC_PORT_OFFHOOK]  <= rom_sync[`SFC_TONE_OFFHOOK];
            TONE_PORT_OUT[`SFC_PORT_RINGING]  <= rom_sync[`SFC_TONE_RINGING];
        end
    end
endmodule // sfc_top

// ===== include/sfc_cfg.svh
// Constants of the stand-alone frame clock source
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

`define SFC_FRAME_LAST     11'h04ff
`define SFC_WIDTH_MIN      11'h0001
`define SFC_WIDTH_MAX      11'h0500
`define SFC_WIDTH_RST      11'h0280

`define SFC_REG_CTRL       5'h00
`define SFC_REG_WIDTH_LO   5'h01
`define SFC_REG_WIDTH_HI   5'h02
`define SFC_REG_PHASE_LO   5'h03
`define SFC_REG_PHASE_HI   5'h04
`define SFC_REG_RAM_PTR    5'h05
`define SFC_REG_RAM_DATA   5'h06
`define SFC_REG_STATUS     5'h07

`define SFC_CTRL_MODE_BIT  0
`define SFC_CTRL_SEL_BIT   1
`define SFC_CTRL_RST       8'h00

`define SFC_SLOT_HOST      5'h01
`define SFC_SLOT_TRUNK     5'h03
`define SFC_SLOT_MAINT     5'h04
`define SFC_BIT_LAST       3'h7

`define SFC_RAM_TX_BASE    5'h10
`define SFC_ROM_LAST       13'h1fff

`define SFC_TONE_DIAL      0
`define SFC_TONE_BUSY      1
`define SFC_TONE_RINGBACK  2
`define SFC_TONE_OFFHOOK   3
`define SFC_TONE_RINGING   4
`define SFC_PORT_DIAL      7
`define SFC_PORT_BUSY      1
`define SFC_PORT_RINGBACK  4
`define SFC_PORT_OFFHOOK   2
`define SFC_PORT_RINGING   5

`endif

// ===== include/sfc_pkg.sv
// Types of the stand-alone frame clock source
package sfc_pkg;
    typedef enum logic [2:0] {
        SFC_BUS_IDLE = 3'b001,
        SFC_BUS_WAIT = 3'b010,
        SFC_BUS_ACK  = 3'b100
    } sfc_bus_state_t;
endpackage

// ===== src/sfc_sync.sv
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module sfc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta  <= '0;
            q_out <= '0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule // sfc_sync

// ===== src/sfc_frame_gen.sv
// Oscillator-domain frame counter, local frame pulse and width pulse
`timescale 1ns/1ps
`include "sfc_cfg.svh"
module sfc_frame_gen #(
    parameter int CW = 11
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          width_req_in,
    input  wire logic [CW-1:0] width_in,
    output logic               local_frame_pulse_out,
    output logic               width_pulse_out,
    output logic               frame_toggle_out
);
    logic [CW-1:0] count;
    logic [CW-1:0] width_pend;
    logic [CW-1:0] width_act;
    logic          req_seen;
    logic          frame_wrap;

    assign frame_wrap = (count == `SFC_FRAME_LAST);

    always_ff @(posedge clk_in) begin
        if (rst_in || frame_wrap) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            local_frame_pulse_out <= 1'b0;
            frame_toggle_out      <= 1'b0;
        end else begin
            local_frame_pulse_out <= frame_wrap;
            if (frame_wrap) begin
                frame_toggle_out <= ~frame_toggle_out;
            end
        end
    end

    // Width word is stable for two cycles before its toggle arrives here
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            req_seen   <= 1'b0;
            width_pend <= `SFC_WIDTH_RST;
            width_act  <= `SFC_WIDTH_RST;
        end else begin
            req_seen <= width_req_in;
            if (req_seen != width_req_in) begin
                width_pend <= width_in;
            end
            if (frame_wrap) begin
                width_act <= width_pend;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            width_pulse_out <= 1'b0;
        end else begin
            width_pulse_out <= (count < width_act);
        end
    end
endmodule // sfc_frame_gen

// ===== sim/sfc_host_model.sv
// Host processor model on the parallel register bus
`timescale 1ns/1ps
module sfc_host_model (
    input  wire logic       clk_in,
    input  wire logic       ack_n_in,
    input  wire logic [7:0] rdata_in,
    output logic      [4:0] addr_out,
    output logic      [7:0] data_out,
    output logic            strobe_n_out,
    output logic            write_n_out
);
    initial begin
        addr_out     = 5'h00;
        data_out     = 8'h00;
        strobe_n_out = 1'b1;
        write_n_out  = 1'b1;
    end

    // Released lines show inverted values, not stale ones
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        int n;
        int m;
        n = 0;
        m = 0;
        @(posedge clk_in);
        #2;
        addr_out     = a;
        data_out     = d;
        write_n_out  = ~wr;
        strobe_n_out = 1'b0;
        while (n < 50 && ack_n_in !== 1'b0) begin
            @(posedge clk_in);
            n++;
        end
        q = rdata_in;
        #2;
        strobe_n_out = 1'b1;
        addr_out     = ~a;
        data_out     = ~d;
        while (m < 50 && ack_n_in !== 1'b1) begin
            @(posedge clk_in);
            m++;
        end
        ok = (n < 50) && (m < 50);
    endtask
endmodule // sfc_host_model

// ===== sim/sfc_top_asserts.sv
// Port checker for the frame clock source
`timescale 1ns/1ps
module sfc_top_asserts (
    input wire logic        SYS_CLK_IN,
    input wire logic        RST_IN,
    input wire logic        OSC_CLK_IN,
    input wire logic [4:0]  PROC_ADDR_IN,
    input wire logic        PROC_STROBE_N_IN,
    input wire logic        PROC_DATA_ACKNOWLEDGE_N_OUT,
    input wire logic        STANDALONE_MODE_OUT,
    input wire logic        HOST_SLOT_TO_DEVICE_OUT,
    input wire logic        MAINT_SLOT_TO_CARD_OUT,
    input wire logic        TRUNK_MSG_SLOT_OUT,
    input wire logic [12:0] TONE_ROM_ADDR_OUT,
    input wire logic [7:0]  TONE_PORT_OUT,
    input wire logic        LOCAL_FRAME_PULSE_OUT,
    input wire logic        WIDTH_PULSE_OUT
);
    logic [10:0] gap;
    logic        seen;
    logic [11:0] hrun;
    // Gap saturates so a lost pulse cannot wrap back into range
    always_ff @(posedge OSC_CLK_IN) begin
        if (RST_IN || LOCAL_FRAME_PULSE_OUT) begin
            gap <= 11'h000;
        end else if (gap != 11'h7ff) begin
            gap <= gap + 11'h001;
        end
    end
    always_ff @(posedge OSC_CLK_IN) begin
        seen <= !RST_IN && (seen || LOCAL_FRAME_PULSE_OUT);
    end
    always_ff @(posedge OSC_CLK_IN) begin
        hrun <= WIDTH_PULSE_OUT ? hrun + 12'h001 : 12'h000;
    end

    property p_ack_answer;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        $fell(PROC_STROBE_N_IN) && PROC_ADDR_IN != 5'h06 |-> ##[2:5] !PROC_DATA_ACKNOWLEDGE_N_OUT;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack late");
    property p_ack_stand;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        !PROC_DATA_ACKNOWLEDGE_N_OUT && !PROC_STROBE_N_IN |=> !PROC_DATA_ACKNOWLEDGE_N_OUT;
    endproperty
    a_ack_stand: assert property (p_ack_stand) else $error("ack dropped early");
    property p_ack_quiet;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        PROC_STROBE_N_IN [*6] |-> PROC_DATA_ACKNOWLEDGE_N_OUT;
    endproperty
    a_ack_quiet: assert property (p_ack_quiet) else $error("ack without strobe");
    property p_trunk_slot;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        STANDALONE_MODE_OUT && $past(STANDALONE_MODE_OUT) |-> !TRUNK_MSG_SLOT_OUT;
    endproperty
    a_trunk_slot: assert property (p_trunk_slot) else $error("trunk slot in stand-alone");
    property p_sa_slots;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        !STANDALONE_MODE_OUT && !$past(STANDALONE_MODE_OUT) |-> !HOST_SLOT_TO_DEVICE_OUT && !MAINT_SLOT_TO_CARD_OUT;
    endproperty
    a_sa_slots: assert property (p_sa_slots) else $error("slot switched in normal mode");
    property p_rom_idle;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        !STANDALONE_MODE_OUT && !$past(STANDALONE_MODE_OUT) |-> TONE_ROM_ADDR_OUT == 13'h0000;
    endproperty
    a_rom_idle: assert property (p_rom_idle) else $error("rom address moves");
    property p_tone_unused;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (TONE_PORT_OUT & 8'h49) == 8'h00;
    endproperty
    a_tone_unused: assert property (p_tone_unused) else $error("tone on unused port");
    property p_frame_gap;
        @(posedge OSC_CLK_IN) disable iff (RST_IN)
        seen |-> (LOCAL_FRAME_PULSE_OUT ? gap == 11'h04ff : gap < 11'h04ff);
    endproperty
    a_frame_gap: assert property (p_frame_gap) else $error("frame not 1280 cycles");
    property p_frame_single;
        @(posedge OSC_CLK_IN) disable iff (RST_IN)
        LOCAL_FRAME_PULSE_OUT |=> !LOCAL_FRAME_PULSE_OUT;
    endproperty
    a_frame_single: assert property (p_frame_single) else $error("frame pulse too long");
    property p_width_run;
        @(posedge OSC_CLK_IN) disable iff (RST_IN)
        $fell(WIDTH_PULSE_OUT) |-> hrun >= 12'h001 && hrun <= 12'h500;
    endproperty
    a_width_run: assert property (p_width_run) else $error("width out of range");

    c_ack: cover property (@(posedge SYS_CLK_IN) $fell(PROC_DATA_ACKNOWLEDGE_N_OUT));
    c_frame: cover property (@(posedge OSC_CLK_IN) seen && LOCAL_FRAME_PULSE_OUT);
    c_width: cover property (@(posedge OSC_CLK_IN) $fell(WIDTH_PULSE_OUT));
endmodule // sfc_top_asserts

bind sfc_top sfc_top_asserts u_sfc_top_asserts (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .OSC_CLK_IN(OSC_CLK_IN), .PROC_ADDR_IN(PROC_ADDR_IN),
    .PROC_STROBE_N_IN(PROC_STROBE_N_IN), .PROC_DATA_ACKNOWLEDGE_N_OUT(PROC_DATA_ACKNOWLEDGE_N_OUT),
    .STANDALONE_MODE_OUT(STANDALONE_MODE_OUT), .HOST_SLOT_TO_DEVICE_OUT(HOST_SLOT_TO_DEVICE_OUT),
    .MAINT_SLOT_TO_CARD_OUT(MAINT_SLOT_TO_CARD_OUT), .TRUNK_MSG_SLOT_OUT(TRUNK_MSG_SLOT_OUT),
    .TONE_ROM_ADDR_OUT(TONE_ROM_ADDR_OUT), .TONE_PORT_OUT(TONE_PORT_OUT),
    .LOCAL_FRAME_PULSE_OUT(LOCAL_FRAME_PULSE_OUT), .WIDTH_PULSE_OUT(WIDTH_PULSE_OUT)
);

// ===== sim/sfc_top_bench.sv
// Self-checking bench for the frame clock source
`timescale 1ns/1ps
`include "sfc_cfg.svh"
module sfc_top_bench;
    logic        sys_clk     = 1'b0;
    logic        osc_clk     = 1'b0;
    logic        rst         = 1'b1;
    logic [1:0]  bclk        = 2'b00;
    logic [1:0]  mfp         = 2'b00;
    logic [7:0]  rom         = 8'h00;
    logic [4:0]  addr;
    logic [7:0]  wdata;
    logic        strobe_n;
    logic        write_n;
    logic [7:0]  rdata;
    logic        ack_n;
    logic        bclk_sel;
    logic        mfp_sel;
    logic        mode;
    logic [12:0] rom_addr;
    logic [7:0]  tone;
    logic        wpulse;
    logic        trunk;
    int          error_cnt   = 0;
    int          check_count = 0;

    always #12.5 sys_clk = ~sys_clk;
    always #3 osc_clk = ~osc_clk;

    sfc_top u_sfc_top (
        .SYS_CLK_IN(sys_clk), .RST_IN(rst), .OSC_CLK_IN(osc_clk), .PROC_ADDR_IN(addr),
        .PROC_DATA_IN(wdata), .PROC_STROBE_N_IN(strobe_n), .PROC_WRITE_N_IN(write_n),
        .PROC_DATA_OUT(rdata), .PROC_DATA_OE_OUT(), .PROC_DATA_ACKNOWLEDGE_N_OUT(ack_n),
        .LINK_BIT_CLOCK_IN(bclk), .MULTIFRAME_PULSE_IN(mfp), .MSG_RX_IN(1'b0), .MSG_TX_OUT(),
        .LINK_BIT_CLOCK_OUT(bclk_sel), .MULTIFRAME_PULSE_OUT(mfp_sel), .STANDALONE_MODE_OUT(mode),
        .HOST_SLOT_TO_DEVICE_OUT(), .MAINT_SLOT_TO_CARD_OUT(), .TRUNK_MSG_SLOT_OUT(trunk),
        .TONE_ROM_DATA_IN(rom), .TONE_ROM_ADDR_OUT(rom_addr), .TONE_PORT_OUT(tone),
        .LOCAL_FRAME_PULSE_OUT(), .WIDTH_PULSE_OUT(wpulse)
    );
    sfc_host_model u_sfc_host_model (
        .clk_in(sys_clk), .ack_n_in(ack_n), .rdata_in(rdata), .addr_out(addr),
        .data_out(wdata), .strobe_n_out(strobe_n), .write_n_out(write_n)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        logic ok;
        u_sfc_host_model.access(wr, a, d, q, ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("ERROR at %0t: bus access timed out", $time);
            conclude();
        end
    endtask

    task automatic t_unmapped();
        logic [7:0] q;
        bus(1'b1, 5'h1f, 8'hff, q);
        bus(1'b0, 5'h1f, 8'h00, q);
        chk(q, 8'h00);
        bus(1'b0, 5'h08, 8'h00, q);
        chk(q, 8'h00);
        $display("unmapped test done");
    endtask
    task automatic t_mux();
        logic [7:0] q;
        @(posedge sys_clk);
        #2;
        bclk = 2'b10;
        mfp  = 2'b01;
        bus(1'b1, `SFC_REG_CTRL, 8'h02, q);
        repeat (8) @(posedge sys_clk);
        chk({bclk_sel, mfp_sel}, 2'b10);
        bus(1'b1, `SFC_REG_CTRL, 8'h00, q);
        repeat (8) @(posedge sys_clk);
        chk({bclk_sel, mfp_sel}, 2'b01);
        repeat (48) begin
            repeat (5) @(posedge sys_clk);
            #2;
            bclk[0] = ~bclk[0];
        end
        chk(trunk, 1'b1);
        bus(1'b0, `SFC_REG_PHASE_HI, 8'h00, q);
        chk(q[7:1], 7'h00);
        $display("mux test done");
    endtask
    task automatic t_tone();
        logic [7:0]  q;
        logic [12:0] a0;
        int          port[5] = '{7, 1, 4, 2, 5};
        bus(1'b1, `SFC_REG_CTRL, 8'h01, q);
        repeat (4) @(posedge sys_clk);
        chk(mode, 1'b1);
        for (int i = 0; i < 5; i++) begin
            #2;
            rom = 8'h01 << i;
            repeat (6) @(posedge sys_clk);
            chk(tone, 16'h0001 << port[i]);
        end
        a0 = rom_addr;
        repeat (700) @(posedge sys_clk);
        chk(rom_addr != a0, 1'b1);
        bus(1'b1, `SFC_REG_CTRL, 8'h00, q);
        repeat (4) @(posedge sys_clk);
        chk(rom_addr, 13'h0000);
        $display("tone test done");
    endtask
    task automatic t_width();
        logic [7:0]  q;
        logic [11:0] hi;
        logic [10:0] w[4]   = '{11'h000, 11'h005, 11'h4ff, 11'h7ff};
        logic [11:0] exp[4] = '{12'h002, 12'h00a, 12'h9fe, 12'ha00};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `SFC_REG_WIDTH_HI, {5'h00, w[i][10:8]}, q);
            bus(1'b1, `SFC_REG_WIDTH_LO, w[i][7:0], q);
            hi = 12'h000;
            // Past the wrap, then two whole frames
            repeat (1400) @(posedge osc_clk);
            repeat (2560) begin
                @(posedge osc_clk);
                hi += wpulse;
            end
            chk(hi, exp[i]);
        end
        $display("width test done");
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        #2;
        rst = 1'b0;
        t_unmapped();
        t_mux();
        t_tone();
        t_width();
        conclude();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        $display("ERROR at %0t: run limit reached", $time);
        conclude();
    end
endmodule // sfc_top_bench
